// File: hw/modem_control.v
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "modem_map.vh"

module modem_control (
   input wire clk,
   input wire rst,
   input wire ref_clk_in,
   input wire tx_serial_in,
   input wire tx_enable_low,
   input wire receive_power_on,
   input wire rx_tone_in,
   input wire ref_freq_choice,
   input wire low_rate_choice,
   input wire high_rate_choice,
   output reg tx_tone_out,
   output reg tx_tone_oe,
   output reg tx_bit_pacing_clock,
   output reg raw_rx_bits,
   output reg rx_recovered_clock,
   output reg retimed_rx_bits,
   output reg signal_present_flag,
   output reg irq,
   input wire [11:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [11:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready
);

   // Tick counts derived from the reference rate
   localparam [31:0] BIT_1200 = `REF_LO_HZ / `BAUD_1200;
   localparam [31:0] BIT_2400 = `REF_LO_HZ / `BAUD_2400;
   localparam [31:0] BIT_4800 = `REF_LO_HZ / `BAUD_4800;
   localparam [31:0] HALF_1200 = `REF_LO_HZ / (2 * `TONE_1200_HZ);
   localparam [31:0] HALF_1800 = `REF_LO_HZ / (2 * `TONE_1800_HZ);
   localparam [31:0] HALF_2400 = `REF_LO_HZ / (2 * `TONE_2400_HZ);
   localparam [31:0] HALF_4800 = `REF_LO_HZ / (2 * `TONE_4800_HZ);

   // Rate decode; both choices high falls back to 1200
   function [1:0] mode_of;
      input low;
      input high;
      begin
         if (low) begin
            mode_of = `MODE_1200;
         end else if (high) begin
            mode_of = `MODE_4800;
         end else begin
            mode_of = `MODE_2400;
         end
      end
   endfunction

   // Reference ticks per bit or per tone half cycle
   function [12:0] ticks_of;
      input [1:0] m;
      input hi;
      input [1:0] kind;
      reg [12:0] base;
      begin
         base = BIT_1200[12:0];
         case (m)
            `MODE_1200: begin
               if (kind == `KIND_BIT) base = BIT_1200[12:0];
               else if (kind == `KIND_MARK) base = HALF_1200[12:0];
               else base = HALF_1800[12:0];
            end
            `MODE_2400: begin
               if (kind == `KIND_BIT) base = BIT_2400[12:0];
               else if (kind == `KIND_MARK) base = HALF_1200[12:0];
               else base = HALF_2400[12:0];
            end
            default: begin
               if (kind == `KIND_BIT) base = BIT_4800[12:0];
               else if (kind == `KIND_MARK) base = HALF_2400[12:0];
               else base = HALF_4800[12:0];
            end
         endcase
         // Four times the count when the fast reference is in use
         ticks_of = hi ? (base << `REF_HI_SHIFT) : base;
      end
   endfunction

   // Two-flop synchronisers; reset levels model the undriven pin defaults
   wire [`PIN_W-1:0] pin_raw = {high_rate_choice, low_rate_choice, ref_freq_choice,
      rx_tone_in, receive_power_on, tx_enable_low, tx_serial_in, ref_clk_in};
   reg [`PIN_W-1:0] pin_meta_reg;
   reg [`PIN_W-1:0] pin_sync_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta_reg <= `PIN_RST;
         pin_sync_reg <= `PIN_RST;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Reference edge detector gives a one-cycle tick per reference period
   reg ref_prev_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_prev_reg <= 1'b0;
      end else begin
         ref_prev_reg <= pin_sync_reg[`PIN_REF];
      end
   end
   wire tick = pin_sync_reg[`PIN_REF] & ~ref_prev_reg;

   wire ref_hi = pin_sync_reg[`PIN_REFSEL];
   wire [1:0] mode = mode_of(pin_sync_reg[`PIN_LOW], pin_sync_reg[`PIN_HIGH]);
   wire [12:0] bit_tk = ticks_of(mode, ref_hi, `KIND_BIT);
   wire [12:0] mark_tk = ticks_of(mode, ref_hi, `KIND_MARK);
   wire [12:0] space_tk = ticks_of(mode, ref_hi, `KIND_SPACE);
   wire [12:0] bit_half = bit_tk >> 1;

   // Transmitter: sections are gated only by their own enable
   wire tx_on = ~pin_sync_reg[`PIN_TXEN_N];
   reg [12:0] tx_bit_cnt_reg;
   reg [12:0] tx_half_cnt_reg;
   reg tx_bit_reg;
   reg tx_ev_reg;
   wire [12:0] tx_half_len = tx_bit_reg ? mark_tk : space_tk;

   // Tone toggles at each half cycle end, so every change sits at a crossing
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_bit_cnt_reg <= 13'h0000;
         tx_half_cnt_reg <= 13'h0000;
         tx_bit_reg <= 1'b0;
         tx_ev_reg <= 1'b0;
         tx_tone_out <= 1'b0;
         tx_tone_oe <= 1'b0;
         tx_bit_pacing_clock <= 1'b1;
      end else if (!tx_on) begin
         tx_bit_cnt_reg <= 13'h0000;
         tx_half_cnt_reg <= 13'h0000;
         tx_bit_reg <= pin_sync_reg[`PIN_TXD]; // First bit ready at enable
         tx_ev_reg <= 1'b0;
         tx_tone_out <= 1'b0;
         tx_tone_oe <= 1'b0;
         tx_bit_pacing_clock <= 1'b1;
      end else begin
         tx_tone_oe <= 1'b1;
         tx_bit_pacing_clock <= (tx_bit_cnt_reg < bit_half);
         tx_ev_reg <= 1'b0;
         if (tick) begin
            if (tx_bit_cnt_reg >= bit_tk - 13'h0001) begin
               // Bit boundary: next bit taken, counters restart at a crossing
               tx_bit_cnt_reg <= 13'h0000;
               tx_half_cnt_reg <= 13'h0000;
               tx_bit_reg <= pin_sync_reg[`PIN_TXD];
               tx_ev_reg <= 1'b1;
               tx_tone_out <= ~tx_tone_out;
            end else begin
               tx_bit_cnt_reg <= tx_bit_cnt_reg + 13'h0001;
               if (tx_half_cnt_reg >= tx_half_len - 13'h0001) begin
                  tx_half_cnt_reg <= 13'h0000;
                  tx_tone_out <= ~tx_tone_out;
               end else begin
                  tx_half_cnt_reg <= tx_half_cnt_reg + 13'h0001;
               end
            end
         end
      end
   end

   // Receiver: crossing interval sets the bit; long half cycle means one
   wire rx_on = pin_sync_reg[`PIN_RXPWR];
   reg rx_tone_prev_reg;
   reg [12:0] rx_ival_reg;
   reg [4:0] cd_cnt_reg;
   reg [12:0] ph_reg;
   reg rx_ev_reg;
   reg cd_on_ev_reg;
   reg cd_off_ev_reg;
   wire rx_edge = pin_sync_reg[`PIN_TONE] ^ rx_tone_prev_reg;
   wire [12:0] ival_lo = space_tk >> 1;
   wire [12:0] ival_hi = mark_tk + (mark_tk >> 1);
   wire [12:0] ival_mid = (mark_tk >> 1) + (space_tk >> 1);
   wire ival_good = (rx_ival_reg > ival_lo) && (rx_ival_reg < ival_hi);
   wire rx_timeout = tick && (rx_ival_reg >= ival_hi);
   wire new_bit = rx_ival_reg > ival_mid;
   wire bit_change = rx_edge && ival_good && (new_bit != raw_rx_bits);
   wire [12:0] fly_step = bit_tk >> `FLY_SHIFT;

   // Demodulator and carrier integrator
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_tone_prev_reg <= 1'b0;
         rx_ival_reg <= 13'h0000;
         cd_cnt_reg <= 5'h00;
         raw_rx_bits <= 1'b0;
         signal_present_flag <= 1'b0;
         cd_on_ev_reg <= 1'b0;
         cd_off_ev_reg <= 1'b0;
      end else if (!rx_on) begin
         rx_tone_prev_reg <= pin_sync_reg[`PIN_TONE];
         rx_ival_reg <= 13'h0000;
         cd_cnt_reg <= 5'h00;
         raw_rx_bits <= 1'b0;
         signal_present_flag <= 1'b0;
         cd_on_ev_reg <= 1'b0;
         cd_off_ev_reg <= signal_present_flag;
      end else begin
         rx_tone_prev_reg <= pin_sync_reg[`PIN_TONE];
         cd_on_ev_reg <= 1'b0;
         cd_off_ev_reg <= 1'b0;
         if (rx_edge) begin
            rx_ival_reg <= 13'h0000;
            if (ival_good) begin
               raw_rx_bits <= new_bit;
               if (cd_cnt_reg != `CD_MAX) cd_cnt_reg <= cd_cnt_reg + 5'h01;
            end else if (cd_cnt_reg != 5'h00) begin
               cd_cnt_reg <= cd_cnt_reg - 5'h01;
            end
         end else if (rx_timeout) begin
            // No crossing in a valid span counts against the carrier
            rx_ival_reg <= 13'h0000;
            if (cd_cnt_reg != 5'h00) cd_cnt_reg <= cd_cnt_reg - 5'h01;
         end else if (tick) begin
            rx_ival_reg <= rx_ival_reg + 13'h0001;
         end
         // Hysteresis keeps the flag from chattering on noise
         if (!signal_present_flag && cd_cnt_reg >= `CD_ON) begin
            signal_present_flag <= 1'b1;
            cd_on_ev_reg <= 1'b1;
         end else if (signal_present_flag && cd_cnt_reg == 5'h00) begin
            signal_present_flag <= 1'b0;
            cd_off_ev_reg <= 1'b1;
         end
      end
   end

   // Flywheel: free-running bit phase, nudged toward each data transition
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_reg <= 13'h0000;
         rx_recovered_clock <= 1'b0;
         retimed_rx_bits <= 1'b0;
         rx_ev_reg <= 1'b0;
      end else if (!rx_on) begin
         ph_reg <= 13'h0000;
         rx_recovered_clock <= 1'b0;
         retimed_rx_bits <= 1'b0;
         rx_ev_reg <= 1'b0;
      end else begin
         rx_recovered_clock <= (ph_reg < bit_half);
         rx_ev_reg <= 1'b0;
         if (bit_change) begin
            // Small steps keep the clock running through missing transitions
            if (ph_reg < bit_half) begin
               ph_reg <= (ph_reg > fly_step) ? ph_reg - fly_step : 13'h0000;
            end else if (ph_reg + fly_step >= bit_tk) begin
               ph_reg <= 13'h0000;
            end else begin
               ph_reg <= ph_reg + fly_step;
            end
         end else if (tick) begin
            if (ph_reg >= bit_tk - 13'h0001) begin
               ph_reg <= 13'h0000;
            end else begin
               ph_reg <= ph_reg + 13'h0001;
            end
         end
         // Mid bit sample on the very edge that drops the recovered clock
         if (rx_recovered_clock && (ph_reg >= bit_half)) begin
            retimed_rx_bits <= raw_rx_bits;
            rx_ev_reg <= 1'b1;
         end
      end
   end

   // Register bus state
   reg [11:0] aw_addr_reg;
   reg aw_have_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_have_reg;
   reg [`EV_W-1:0] status_reg;
   reg [`EV_W-1:0] mask_reg;
   wire do_write = aw_have_reg && w_have_reg && !bvalid;
   wire wr_status = do_write && (aw_addr_reg == `ADDR_STATUS) && w_strb_reg[0];
   wire wr_mask = do_write && (aw_addr_reg == `ADDR_MASK) && w_strb_reg[0];
   wire wr_known = (aw_addr_reg == `ADDR_STATUS) || (aw_addr_reg == `ADDR_MASK) ||
      (aw_addr_reg == `ADDR_STATE);
   wire [`EV_W-1:0] events = {cd_off_ev_reg, cd_on_ev_reg, rx_ev_reg, tx_ev_reg};
   wire [`EV_W-1:0] w1c = wr_status ? w_data_reg[`EV_W-1:0] : {`EV_W{1'b0}};
   // A new event beats a clear landing in the same cycle
   wire [`EV_W-1:0] status_next = (status_reg & ~w1c) | events;
   wire [`EV_W-1:0] mask_next = wr_mask ? w_data_reg[`EV_W-1:0] : mask_reg;
   wire [31:0] state_word = {25'h0000000, (mode == `MODE_4800) && !ref_hi, ref_hi,
      mode, rx_on, tx_on, signal_present_flag};

   // Write channel: address and data taken in either order, one write at a time
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         status_reg <= {`EV_W{1'b0}};
         mask_reg <= {`EV_W{1'b0}};
         irq <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_addr_reg <= awaddr;
            aw_have_reg <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
            w_have_reg <= 1'b1;
            wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_DECERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq <= |(status_next & mask_next);
      end
   end

   // Read channel: one outstanding read, unmapped reads answer zero with an error
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `RESP_OKAY;
         case (araddr)
            `ADDR_STATUS: rdata <= {28'h0000000, status_reg};
            `ADDR_MASK: rdata <= {28'h0000000, mask_reg};
            `ADDR_STATE: rdata <= state_word;
            default: begin
               rdata <= 32'h00000000;
               rresp <= `RESP_DECERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule // modem_control

// File: hw/modem_map.vh
`ifndef MODEM_MAP_VH
`define MODEM_MAP_VH
// Summary of operation
// - Signal present flag is high while a valid tone signal is received.
// - Low rate choice high: 1200 baud, one is 1200Hz cycle, zero 1.5 cycles 1800Hz.
// - Both choices low: 2400 baud, one is half 1200Hz cycle, zero one 2400Hz cycle.
// - High choice only: 4800 baud, one is half 2400Hz cycle, zero one 4800Hz cycle.
// - Dividers run from 4.032MHz when ref choice high, 1.008MHz when low.
// - Undriven selects default to 1.008MHz reference and 1200 baud.
// - With transmit enable low, serial bits are sampled and sent as tones.
// - Pacing clock is a bit-rate square wave timing each new transmit bit.
// - With receive power on, demodulated bits appear unretimed on raw output.
// - Flywheel recovers the bit clock; clock and retimed bits are output.
// - Transmit and receive sections powersave independently by their own enables.
// - Transmit disabled: powersave, pacing clock held at one, tone output undriven.
// - Retimed bits change on edges of the recovered receive clock.
// - Receive power off: receiver in powersave, retimed bits held at zero.

// Rates in Hz and baud, and the fast reference shift
`define REF_LO_HZ 1008000
`define REF_HI_SHIFT 2
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define TONE_1200_HZ 1200
`define TONE_1800_HZ 1800
`define TONE_2400_HZ 2400
`define TONE_4800_HZ 4800

// Rate modes
`define MODE_1200 2'h0
`define MODE_2400 2'h1
`define MODE_4800 2'h2

// Tick table selectors
`define KIND_BIT 2'h0
`define KIND_MARK 2'h1
`define KIND_SPACE 2'h2

// Synchronised pin vector layout and reset levels (undriven defaults)
`define PIN_W 8
`define PIN_REF 0
`define PIN_TXD 1
`define PIN_TXEN_N 2
`define PIN_RXPWR 3
`define PIN_TONE 4
`define PIN_REFSEL 5
`define PIN_LOW 6
`define PIN_HIGH 7
`define PIN_RST 8'h44

// Carrier detect integrator and flywheel step
`define CD_ON 5'h10
`define CD_MAX 5'h1F
`define FLY_SHIFT 4

// Register map and fields
`define ADDR_STATUS 12'h000
`define ADDR_MASK 12'h004
`define ADDR_STATE 12'h008
`define EV_W 4
`define EV_TX_BIT 0
`define EV_RX_BIT 1
`define EV_CD_ON 2
`define EV_CD_OFF 3
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// File: tb/mcu_model.sv
`timescale 1ns/1ps
// Data source and sink beside the modem: bits on the pacing clock, tone looped back
module mcu_model (
   input wire clk,
   input wire rst,
   input wire tx_bit_pacing_clock,
   input wire tx_tone_out,
   input wire tx_tone_oe,
   input wire rx_recovered_clock,
   output reg tx_serial_in,
   output wire rx_tone_in,
   output reg [15:0] rx_clk_count
);
   integer seed = 32'h06BD;
   reg pace_last;
   reg tone_last;
   reg rclk_last;
   // New bit on the falling pacing edge, so it is settled well before the boundary
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_serial_in <= 1'b0;
         pace_last <= 1'b1;
         tone_last <= 1'b0;
         rclk_last <= 1'b0;
         rx_clk_count <= 16'h0000;
      end else begin
         pace_last <= tx_bit_pacing_clock;
         if (pace_last && !tx_bit_pacing_clock) begin
            tx_serial_in <= ^($random(seed));
         end
         if (tx_tone_oe) begin
            tone_last <= tx_tone_out;
         end
         rclk_last <= rx_recovered_clock;
         if (!rclk_last && rx_recovered_clock) begin
            rx_clk_count <= rx_clk_count + 16'h0001;
         end
      end
   end
   // A released tone pin reads as the inverse of its last driven level and holds there
   assign rx_tone_in = tx_tone_oe ? tx_tone_out : ~tone_last;
endmodule // mcu_model

// File: tb/modem_control_sva.sv
`timescale 1ns/1ps
// Port-level checks of powersave, retiming and register bus handshakes
module modem_checker (
   input wire clk,
   input wire rst,
   input wire tx_enable_low,
   input wire receive_power_on,
   input wire tx_tone_out,
   input wire tx_tone_oe,
   input wire tx_bit_pacing_clock,
   input wire raw_rx_bits,
   input wire rx_recovered_clock,
   input wire retimed_rx_bits,
   input wire signal_present_flag,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   input wire rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Five samples cover the pin synchroniser plus the output register
   a_pacing_idle: assert property (tx_enable_low [*5] |-> tx_bit_pacing_clock && !tx_tone_oe)
      else $error("transmitter active while disabled");
   a_tone_drive: assert property (!tx_enable_low [*5] |-> tx_tone_oe)
      else $error("tone pin not driven while enabled");
   a_tone_quiet: assert property (!tx_tone_oe |-> !tx_tone_out)
      else $error("tone toggles while released");
   a_rx_quiet: assert property (!receive_power_on [*5] |-> !retimed_rx_bits && !raw_rx_bits
      && !rx_recovered_clock && !signal_present_flag)
      else $error("receiver outputs active in powersave");
   a_retime_edge: assert property ($rose(retimed_rx_bits) |-> $fell(rx_recovered_clock)
      || ($past(rx_recovered_clock, 2) && !$past(rx_recovered_clock)))
      else $error("retimed data moved off the recovered clock edge");
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |=> !awready && !wready ##1 bvalid)
      else $error("write response timing wrong");
   a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read response timing wrong");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
   a_rresp_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response dropped before taken");
endmodule // modem_checker

bind modem_control modem_checker u_chk (.clk, .rst, .tx_enable_low, .receive_power_on,
   .tx_tone_out, .tx_tone_oe, .tx_bit_pacing_clock, .raw_rx_bits, .rx_recovered_clock,
   .retimed_rx_bits, .signal_present_flag, .awvalid, .awready, .wvalid, .wready, .bresp,
   .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// File: tb/tb.sv
`timescale 1ns/1ps
`include "modem_map.vh"
// Rate table sweep, loop-back carrier detect, interrupt and register checks
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg ref_clk_in = 1'b0;
   reg tx_enable_low = 1'b1;
   reg receive_power_on = 1'b0;
   reg ref_freq_choice = 1'b0;
   reg low_rate_choice = 1'b1;
   reg high_rate_choice = 1'b0;
   reg [11:0] awaddr = 12'h000;
   reg awvalid = 1'b0;
   reg [31:0] wdata = 32'h00000000;
   reg [3:0] wstrb = 4'h0;
   reg wvalid = 1'b0;
   reg bready = 1'b0;
   reg [11:0] araddr = 12'h000;
   reg arvalid = 1'b0;
   reg rready = 1'b0;
   wire tx_serial_in, rx_tone_in, tx_tone_out, tx_tone_oe, tx_bit_pacing_clock, raw_rx_bits;
   wire rx_recovered_clock, retimed_rx_bits, signal_present_flag, irq;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] rx_clk_count;
   integer err_count = 0;
   integer num_checks = 0;
   integer seed = 32'h06BD;
   integer i, n;
   reg [31:0] rd, m;
   reg [1:0] rs;
   reg [4:0] lo = 5'b01001;
   reg [4:0] hi = 5'b01100; // 4800 only on the fast reference
   reg [4:0] rf = 5'b00100;

   always #2 clk = ~clk;
   // Reference offset so its edges never coincide with the system clock
   initial begin
      #7;
      forever #24 ref_clk_in = ~ref_clk_in;
   end

   modem_control dut (.clk, .rst, .ref_clk_in, .tx_serial_in, .tx_enable_low, .receive_power_on,
      .rx_tone_in, .ref_freq_choice, .low_rate_choice, .high_rate_choice, .tx_tone_out,
      .tx_tone_oe, .tx_bit_pacing_clock, .raw_rx_bits, .rx_recovered_clock, .retimed_rx_bits,
      .signal_present_flag, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   mcu_model partner (.clk, .rst, .tx_bit_pacing_clock, .tx_tone_out, .tx_tone_oe,
      .rx_recovered_clock, .tx_serial_in, .rx_tone_in, .rx_clk_count);

   task summarize;
      begin
         $display("checks %0d, errors %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         num_checks++;
         if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
         end
      end
   endtask
   task bound(input integer k, input integer lim);
      if (k >= lim) begin
         err_count++;
         $display("unexpected wait length: expected under %0d, seen %0d", lim, k);
         summarize;
      end
   endtask
   // Response is left standing one cycle so the slave must hold it
   task axi_write(input [11:0] a, input [31:0] d);
      integer k;
      reg aw, w;
      begin
         awaddr <= a;
         wdata <= d;
         wstrb <= 4'hF;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         aw = 1'b1;
         w = 1'b1;
         k = 0;
         while ((aw || w) && k < 50) begin
            @(posedge clk);
            k++;
            if (aw && awready === 1'b1) begin
               awvalid <= 1'b0;
               aw = 1'b0;
            end
            if (w && wready === 1'b1) begin
               wvalid <= 1'b0;
               w = 1'b0;
            end
         end
         bound(k, 50);
         repeat (2) @(posedge clk);
         bready <= 1'b1;
         k = 0;
         do begin @(posedge clk); k++; end while (bvalid !== 1'b1 && k < 50);
         bound(k, 50);
         rs = bresp;
         bready <= 1'b0;
      end
   endtask
   task axi_read(input [11:0] a);
      integer k;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         k = 0;
         do begin @(posedge clk); k++; end while (arready !== 1'b1 && k < 50);
         arvalid <= 1'b0;
         bound(k, 50);
         @(posedge clk);
         rready <= 1'b1;
         k = 0;
         do begin @(posedge clk); k++; end while (rvalid !== 1'b1 && k < 50);
         bound(k, 50);
         rd = rdata;
         rs = rresp;
         rready <= 1'b0;
      end
   endtask
   function [31:0] state_exp(input f, input t, input r, input l, input h, input q);
      reg [1:0] md;
      begin
         md = l ? `MODE_1200 : (h ? `MODE_4800 : `MODE_2400);
         state_exp = {25'h0, (md == `MODE_4800) && !q, q, md, r, t, f};
      end
   endfunction
   // Reference ticks per bit; the fast reference needs four times as many
   function integer bit_ticks(input l, input h, input q);
      bit_ticks = `REF_LO_HZ / (l ? `BAUD_1200 : (h ? `BAUD_4800 : `BAUD_2400))
         * (q ? (1 << `REF_HI_SHIFT) : 1);
   endfunction
   function near(input integer x, input integer a);
      near = (x >= a - 1) && (x <= a + 1);
   endfunction
   task wait_rise;
      integer k;
      reg p;
      begin
         k = 0;
         p = 1'b1;
         while (k < 30000) begin
            @(posedge clk);
            k++;
            if (p === 1'b0 && tx_bit_pacing_clock === 1'b1) break;
            p = tx_bit_pacing_clock;
         end
         bound(k, 30000);
      end
   endtask
   // One full bit: pacing period and duty, and each tone half-cycle inside it after the first
   task measure(input integer bt, input l);
      integer k, h, t;
      reg p, tp;
      begin
         wait_rise;
         k = 0;
         h = 0;
         t = -1;
         p = 1'b1;
         tp = tx_tone_out;
         while (k < 30000) begin
            @(posedge clk);
            k++;
            if (p === 1'b0 && tx_bit_pacing_clock === 1'b1) break;
            p = tx_bit_pacing_clock;
            if (p === 1'b1) h++;
            if (tx_tone_out !== tp) begin
               if (t >= 0) chk("tone half", 1, near(t + 1, (l ? bt / 2 : bt) * 12)
                  || near(t + 1, (l ? bt / 3 : bt / 2) * 12));
               t = 0;
               tp = tx_tone_out;
            end else if (t >= 0) t++;
         end
         chk("pacing period", bt * 12, k);
         chk("pacing high", bt * 6, h + 1);
      end
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("pacing", 1, tx_bit_pacing_clock);
      axi_read(`ADDR_STATE);
      chk("state", state_exp(0, 0, 0, 1, 0, 0), rd);
      axi_read(`ADDR_MASK);
      chk("mask", 0, rd);
      axi_read(12'h010);
      chk("read resp", `RESP_DECERR, rs);
      chk("read data", 0, rd);
      axi_write(12'h0F0, 32'hFFFFFFFF);
      chk("write resp", `RESP_DECERR, rs);
      for (i = 0; i < 4; i++) begin
         m = $random(seed) & 32'h0000000F;
         axi_write(`ADDR_MASK, m);
         axi_read(`ADDR_MASK);
         chk("mask", m, rd);
      end
      axi_write(`ADDR_STATE, 32'hFFFFFFFF);
      axi_read(`ADDR_STATE);
      chk("state", state_exp(0, 0, 0, 1, 0, 0), rd);
      tx_enable_low <= 1'b0;
      // Last row is 2400 on the slow reference, the quickest legal tones; the receiver
      // starts there so carrier acquisition overlaps the last measurement
      for (i = 0; i < 5; i++) begin
         low_rate_choice <= lo[i];
         high_rate_choice <= hi[i];
         ref_freq_choice <= rf[i];
         repeat (4) @(posedge clk);
         axi_read(`ADDR_STATE);
         chk("state", state_exp(0, 1, 0, lo[i], hi[i], rf[i]), rd);
         if (i == 4) receive_power_on <= 1'b1;
         if (i != 3) measure(bit_ticks(lo[i], hi[i], rf[i]), lo[i]);
      end
      axi_write(`ADDR_MASK, 32'h00000001 << `EV_CD_ON);
      n = 0;
      while (signal_present_flag !== 1'b1 && n < 60000) begin
         @(posedge clk);
         n++;
      end
      bound(n, 60000);
      axi_read(`ADDR_STATE);
      chk("state", state_exp(1, 1, 1, 0, 0, 0), rd);
      chk("irq", 1, irq);
      axi_read(`ADDR_STATUS);
      chk("status", 1, rd[`EV_CD_ON]);
      axi_write(`ADDR_STATUS, 32'h00000001 << `EV_CD_ON);
      repeat (3) @(posedge clk);
      chk("irq", 0, irq);
      chk("rx clock", 1, rx_clk_count > 16'h0000);
      receive_power_on <= 1'b0;
      repeat (6) @(posedge clk);
      chk("retimed", 0, retimed_rx_bits);
      chk("tone enable", 1, tx_tone_oe);
      tx_enable_low <= 1'b1;
      repeat (6) @(posedge clk);
      chk("pacing", 1, tx_bit_pacing_clock);
      chk("tone enable", 0, tx_tone_oe);
      summarize;
   end
endmodule // tb
